/* File: verilog/dtc_consts.svh */
// Register offsets, field positions and reset values of the timing config block
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH

`define DTC_OFS_WTR        12'h03c
`define DTC_OFS_PDX        12'h040
`define DTC_OFS_SRX        12'h044
`define DTC_OFS_SRE        12'h048
`define DTC_OFS_MEM2       12'h04c
`define DTC_OFS_REF        12'h050
`define DTC_OFS_QOS_LO     12'h100
`define DTC_OFS_QOS_HI     12'h13c
`define DTC_OFS_CHIP0      12'h200
`define DTC_OFS_STATE      12'h300

`define DTC_RST_WTR        3'h2
`define DTC_RST_PDX        8'h01
`define DTC_RST_SRX        8'h0a
`define DTC_RST_SRE        8'h14
`define DTC_RST_MEM2       11'h000
`define DTC_RST_REF        12'h000
`define DTC_RST_QOS        10'h000
`define DTC_RST_CHIP0      17'h0ff00

`define DTC_MEM2_RDLY_HI   10
`define DTC_MEM2_RDLY_LO   9
`define DTC_MEM2_KIND_HI   8
`define DTC_MEM2_KIND_LO   6
`define DTC_MEM2_WID_HI    5
`define DTC_MEM2_WID_LO    4
`define DTC_MEM2_CKE       3
`define DTC_MEM2_DQM       2
`define DTC_MEM2_FAST      1
`define DTC_MEM2_SYNC      0
`define DTC_REF_PRE_HI     11
`define DTC_REF_PRE_LO     3
`define DTC_REF_OUT_HI     2
`define DTC_REF_OUT_LO     0
`define DTC_QOS_MAX_HI     9
`define DTC_QOS_MAX_LO     2
`define DTC_QOS_MIN        1
`define DTC_QOS_EN         0
`define DTC_CH0_ORG        16
`define DTC_CH0_MATCH_HI   15
`define DTC_CH0_MATCH_LO   8
`define DTC_CH0_MASK_HI    7
`define DTC_CH0_MASK_LO    0
`define DTC_QOS_ENTRIES    16
`define DTC_ID_SHIFT       5

`endif

/* File: verilog/dtc_pkg.sv */
// Types shared by the timing config block
package dtc_pkg;
	typedef enum logic [2:0] {
		DTC_KIND_SDR   = 3'h0,
		DTC_KIND_DDR   = 3'h1,
		DTC_KIND_EDRAM = 3'h2,
		DTC_KIND_LPDDR = 3'h3
	} dtc_kind_t;
	typedef enum logic [1:0] {
		DTC_WID_16  = 2'h0,
		DTC_WID_32  = 2'h1,
		DTC_WID_64  = 2'h2,
		DTC_WID_RES = 2'h3
	} dtc_width_t;
	typedef enum {
		DTC_WAIT_IDLE,
		DTC_WAIT_WTR,
		DTC_WAIT_PDX,
		DTC_WAIT_SRX,
		DTC_WAIT_SRE
	} dtc_wait_t;
endpackage

/* File: verilog/dtc_gap_timer.sv */
// Down-counter that holds off commands for a programmed number of memory clocks
`timescale 1ns/1ps
`default_nettype none
module dtc_gap_timer #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// One pulse per memory clock cycle
	input  wire logic             mclk_tick,
	// Start with count
	input  wire logic             start,
	input  wire logic [WIDTH-1:0] count,
	// Hold-off level
	output logic                  busy
);
	logic [WIDTH-1:0] remain;
	logic [WIDTH-1:0] next_remain;

	// Zero count means no hold-off at all
	assign next_remain = start ? count :
		(mclk_tick && remain != '0) ? remain - 1'b1 : remain;
	assign busy = remain != '0;

	// Remaining memory clocks
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			remain <= '0;
		end else begin
			remain <= next_remain;
		end
	end
endmodule
`default_nettype wire

/* File: verilog/dtc_top.sv */
// Timing and configuration registers of the DRAM controller, AXI4-Lite slave
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "dtc_consts.svh"

module dtc_top
	import dtc_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite write address
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Controller state from scheduler
	input  wire logic              cfg_state,
	input  wire logic              low_power_state,
	input  wire logic              mclk_tick,
	// Command events from scheduler
	input  wire logic              write_issued,
	input  wire logic              read_wanted,
	input  wire logic              powerdown_exit,
	input  wire logic              selfrefresh_exit,
	input  wire logic              selfrefresh_entry,
	output logic                   read_hold,
	output logic                   command_hold,
	// Memory setup outputs
	output logic [1:0]             pad_read_latency,
	output dtc_kind_t              memory_kind,
	output dtc_width_t             memory_width,
	output logic                   width_reserved,
	output logic                   cke_out,
	output logic                   dqm_out,
	output logic                   bus_faster_synchronous,
	output logic                   clocks_synchronous,
	// Refresh setup
	output logic [8:0]             refresh_prescale,
	output logic [2:0]             refresh_max_outstanding,
	// QoS lookup by master identifier
	input  wire logic [7:0]        master_id,
	output logic                   qos_enable,
	output logic                   qos_min,
	output logic [7:0]             qos_max,
	// Chip zero decode
	input  wire logic [31:0]       bus_addr,
	output logic                   chip_zero_select,
	output logic                   bank_row_column
);
	localparam int NQ = `DTC_QOS_ENTRIES;

	logic [2:0]  write_read_turnaround;
	logic [7:0]  powerdown_exit_time;
	logic [7:0]  selfrefresh_exit_time;
	logic [7:0]  selfrefresh_entry_time;
	logic [10:0] memory_setup_second;
	logic [11:0] refresh_setup;
	logic [9:0]  master_qos_setup [NQ];
	logic [16:0] chip_zero_decode;

	logic              aw_held;
	logic              w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0]       w_data;
	logic [3:0]        w_strb;
	logic [31:0]       rd_word;
	logic              rd_ok;
	logic              wr_ok;
	logic              do_write;
	logic              do_read;
	logic              cfg_open;
	logic              mem_out_live;
	logic              wtr_busy;
	logic              pdx_busy;
	logic              srx_busy;
	logic              sre_busy;
	logic [31:0]       wmask;
	dtc_wait_t         wait_state;
	dtc_wait_t         next_wait_state;

	// Only these states let software touch guarded registers
	assign cfg_open = cfg_state | low_power_state;

	// Strobe to bit mask
	assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}},
		{8{w_strb[1]}}, {8{w_strb[0]}}};

	// Channel readiness: one write and one read in flight at most
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign do_read  = s_axi_arvalid && s_axi_arready;

	// Write decode; guarded offsets refuse outside config and low-power states
	function automatic logic wr_hit(input logic [ADDR_W-1:0] a,
		input logic open);
		logic [11:0] o;
		o = 12'(a);
		case (o)
			`DTC_OFS_WTR, `DTC_OFS_SRX, `DTC_OFS_SRE,
			`DTC_OFS_REF, `DTC_OFS_CHIP0: wr_hit = open;
			`DTC_OFS_PDX, `DTC_OFS_MEM2: wr_hit = 1'b1;
			default: wr_hit = (o >= `DTC_OFS_QOS_LO) &&
				(o <= `DTC_OFS_QOS_HI) && (o[1:0] == 2'h0) && open;
		endcase
	endfunction
	assign wr_ok = wr_hit(aw_addr, cfg_open);
	assign rd_ok = wr_hit(s_axi_araddr, cfg_open) ||
		(12'(s_axi_araddr) == `DTC_OFS_STATE);

	// Read mux, reserved bits zero
	always_comb begin
		logic [11:0] o;
		o = 12'(s_axi_araddr);
		rd_word = 32'h0000_0000;
		case (o)
			`DTC_OFS_WTR:   rd_word = {29'h0, write_read_turnaround};
			`DTC_OFS_PDX:   rd_word = {24'h0, powerdown_exit_time};
			`DTC_OFS_SRX:   rd_word = {24'h0, selfrefresh_exit_time};
			`DTC_OFS_SRE:   rd_word = {24'h0, selfrefresh_entry_time};
			`DTC_OFS_MEM2:  rd_word = {21'h0, memory_setup_second};
			`DTC_OFS_REF:   rd_word = {20'h0, refresh_setup};
			`DTC_OFS_CHIP0: rd_word = {15'h0, chip_zero_decode};
			`DTC_OFS_STATE: rd_word = {26'h0, sre_busy, srx_busy, pdx_busy,
				wtr_busy, low_power_state, cfg_state};
			default: begin
				if (o >= `DTC_OFS_QOS_LO && o <= `DTC_OFS_QOS_HI)
					rd_word = {22'h0, master_qos_setup[o[5:2]]};
			end
		endcase
	end

	// Capture write address and data in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= '0;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (do_write) begin
				w_held <= 1'b0;
			end
		end
	end

	// Responses; refused access answers SLVERR
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp  <= 2'h0;
			s_axi_rdata  <= 32'h0000_0000;
		end else begin
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (do_read) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
				s_axi_rdata  <= rd_ok ? rd_word : 32'h0000_0000;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Scalar registers with byte strobes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			write_read_turnaround  <= `DTC_RST_WTR;
			powerdown_exit_time    <= `DTC_RST_PDX;
			selfrefresh_exit_time  <= `DTC_RST_SRX;
			selfrefresh_entry_time <= `DTC_RST_SRE;
			memory_setup_second    <= `DTC_RST_MEM2;
			refresh_setup          <= `DTC_RST_REF;
			chip_zero_decode       <= `DTC_RST_CHIP0;
		end else if (do_write && wr_ok) begin
			case (12'(aw_addr))
				`DTC_OFS_WTR: write_read_turnaround <= 3'((w_data & wmask) |
					({29'h0, write_read_turnaround} & ~wmask));
				`DTC_OFS_PDX: powerdown_exit_time <= 8'((w_data & wmask) |
					({24'h0, powerdown_exit_time} & ~wmask));
				`DTC_OFS_SRX: selfrefresh_exit_time <= 8'((w_data & wmask) |
					({24'h0, selfrefresh_exit_time} & ~wmask));
				`DTC_OFS_SRE: selfrefresh_entry_time <= 8'((w_data & wmask) |
					({24'h0, selfrefresh_entry_time} & ~wmask));
				`DTC_OFS_MEM2: memory_setup_second <= 11'((w_data & wmask) |
					({21'h0, memory_setup_second} & ~wmask));
				`DTC_OFS_REF: refresh_setup <= 12'((w_data & wmask) |
					({20'h0, refresh_setup} & ~wmask));
				`DTC_OFS_CHIP0: chip_zero_decode <= 17'((w_data & wmask) |
					({15'h0, chip_zero_decode} & ~wmask));
				default: ;
			endcase
		end
	end

	// One QoS entry per word in the QoS window
	generate
		for (genvar i = 0; i < NQ; i++) begin : g_qos
			wire hit_q = do_write && wr_ok &&
				(12'(aw_addr) == 12'(`DTC_OFS_QOS_LO + 4 * i));
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					master_qos_setup[i] <= `DTC_RST_QOS;
				end else if (hit_q) begin
					master_qos_setup[i] <= 10'((w_data & wmask) |
						({22'h0, master_qos_setup[i]} & ~wmask));
				end
			end
		end
	endgenerate

	// Memory setup fields out to the pad side
	assign pad_read_latency = memory_setup_second[`DTC_MEM2_RDLY_HI:
		`DTC_MEM2_RDLY_LO];
	assign memory_kind = dtc_kind_t'(memory_setup_second[`DTC_MEM2_KIND_HI:
		`DTC_MEM2_KIND_LO]);
	assign memory_width = dtc_width_t'(memory_setup_second[`DTC_MEM2_WID_HI:
		`DTC_MEM2_WID_LO]);
	assign width_reserved = memory_width == DTC_WID_RES;
	assign bus_faster_synchronous = memory_setup_second[`DTC_MEM2_FAST];
	assign clocks_synchronous = memory_setup_second[`DTC_MEM2_SYNC];
	assign refresh_prescale = refresh_setup[`DTC_REF_PRE_HI:`DTC_REF_PRE_LO];
	assign refresh_max_outstanding = refresh_setup[`DTC_REF_OUT_HI:
		`DTC_REF_OUT_LO];

	// Init levels hold until the controller first leaves config state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mem_out_live <= 1'b0;
		end else if (!cfg_state) begin
			mem_out_live <= 1'b1;
		end
	end
	assign cke_out = mem_out_live ? 1'b1 :
		memory_setup_second[`DTC_MEM2_CKE];
	assign dqm_out = mem_out_live ? 1'b0 :
		memory_setup_second[`DTC_MEM2_DQM];

	// Master id upper bits pick its entry
	wire [3:0] qos_sel = 4'(master_id >> `DTC_ID_SHIFT);
	assign qos_enable = master_qos_setup[qos_sel][`DTC_QOS_EN];
	assign qos_min    = master_qos_setup[qos_sel][`DTC_QOS_MIN];
	assign qos_max    = master_qos_setup[qos_sel][`DTC_QOS_MAX_HI:
		`DTC_QOS_MAX_LO];

	// Chip zero decode; zero mask selects everything
	wire [7:0] ch0_mask  = chip_zero_decode[`DTC_CH0_MASK_HI:
		`DTC_CH0_MASK_LO];
	wire [7:0] ch0_match = chip_zero_decode[`DTC_CH0_MATCH_HI:
		`DTC_CH0_MATCH_LO];
	assign chip_zero_select = (bus_addr[31:24] & ch0_mask) ==
		(ch0_match & ch0_mask);
	assign bank_row_column = chip_zero_decode[`DTC_CH0_ORG];

	// Gap timers, one per command spacing
	dtc_gap_timer #(.WIDTH(3)) u_wtr (
		.aclk(aclk), .aresetn(aresetn), .mclk_tick(mclk_tick),
		.start(write_issued), .count(write_read_turnaround),
		.busy(wtr_busy));
	dtc_gap_timer #(.WIDTH(8)) u_pdx (
		.aclk(aclk), .aresetn(aresetn), .mclk_tick(mclk_tick),
		.start(powerdown_exit), .count(powerdown_exit_time),
		.busy(pdx_busy));
	dtc_gap_timer #(.WIDTH(8)) u_srx (
		.aclk(aclk), .aresetn(aresetn), .mclk_tick(mclk_tick),
		.start(selfrefresh_exit), .count(selfrefresh_exit_time),
		.busy(srx_busy));
	dtc_gap_timer #(.WIDTH(8)) u_sre (
		.aclk(aclk), .aresetn(aresetn), .mclk_tick(mclk_tick),
		.start(selfrefresh_entry), .count(selfrefresh_entry_time),
		.busy(sre_busy));

	// Hold-off outputs; read_wanted gates read_hold, so reads are held only while one is wanted
	assign read_hold    = wtr_busy && read_wanted;
	assign command_hold = pdx_busy || srx_busy || sre_busy;

	// Summary of which wait dominates, srx first; kept internal, not in the read mux
	always_comb begin
		next_wait_state = DTC_WAIT_IDLE;
		case (1'b1)
			srx_busy: next_wait_state = DTC_WAIT_SRX;
			sre_busy: next_wait_state = DTC_WAIT_SRE;
			pdx_busy: next_wait_state = DTC_WAIT_PDX;
			wtr_busy: next_wait_state = DTC_WAIT_WTR;
			default:  next_wait_state = DTC_WAIT_IDLE;
		endcase
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wait_state <= DTC_WAIT_IDLE;
		end else begin
			wait_state <= next_wait_state;
		end
	end
endmodule
`default_nettype wire

/* File: dv/dtc_monitor.sv */
// Concurrent checks on the ports of the timing config block
`timescale 1ns/1ps
`default_nettype none
module dtc_monitor
	import dtc_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input wire logic              aclk,
	input wire logic              aresetn,
	// Register bus
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic [1:0]        s_axi_rresp,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	// Controller state and outputs
	input wire logic              cfg_state,
	input wire logic              low_power_state,
	input wire logic              read_wanted,
	input wire logic              read_hold,
	input wire dtc_width_t        memory_width,
	input wire logic              width_reserved,
	input wire logic              cke_out,
	input wire logic              dqm_out
);
	// Single clock domain; reset silences every check
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid)
		else $error("read not answered next cycle");
	a_guard_read: assert property (s_axi_arvalid && s_axi_arready
		&& !cfg_state && !low_power_state && s_axi_araddr == 12'h03c
		|=> s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
		else $error("guarded read not refused");
	a_open_write: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready && s_axi_awaddr == 12'h040
		|-> ##[1:3] s_axi_bvalid && s_axi_bresp == 2'b00)
		else $error("open register write refused");
	a_width_flag: assert property (width_reserved
		== (memory_width == DTC_WID_RES))
		else $error("reserved width flag wrong");
	a_cke_release: assert property (!cfg_state
		|=> cke_out && !dqm_out)
		else $error("clock enable or mask not released");
	a_read_gate: assert property ($fell(read_wanted) || !read_wanted
		|-> !read_hold)
		else $error("read held with no read wanted");
endmodule

bind dtc_top dtc_monitor #(.ADDR_W(ADDR_W)) i_mon (
	.aclk(aclk), .aresetn(aresetn),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .cfg_state(cfg_state),
	.low_power_state(low_power_state), .read_wanted(read_wanted),
	.read_hold(read_hold), .memory_width(memory_width),
	.width_reserved(width_reserved), .cke_out(cke_out),
	.dqm_out(dqm_out));
`default_nettype wire

/* File: dv/dtc_mem_model.sv */
// Memory-side model: supplies the memory clock tick at a fixed ratio
`timescale 1ns/1ps
`default_nettype none
module dtc_mem_model #(
	parameter int DIV = 2
) (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// One pulse per memory clock cycle
	output logic      mclk_tick
);
	logic [7:0] phase;

	// Memory clock runs free at aclk/DIV, so each counted gap clock spans DIV bus cycles
	always_ff @(posedge aclk) begin
		if (!aresetn || mclk_tick) begin
			phase <= 8'h00;
		end else begin
			phase <= phase + 8'h01;
		end
	end
	assign mclk_tick = (phase == 8'(DIV - 1));
endmodule
`default_nettype wire

/* File: dv/dtc_top_tb.sv */
// Self-checking bench for the timing config block
`timescale 1ns/1ps
`default_nettype none
module dtc_top_tb;
	import dtc_pkg::*;
	logic        aclk = 0, aresetn = 0;
	logic [11:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, baddr = 0;
	logic [3:0]  wstrb = 0, ev = 0;
	logic        awvalid = 0, wvalid = 0, bready = 0;
	logic        arvalid = 0, rready = 0, cfg = 1, lp = 0, rw = 0;
	logic [7:0]  mid = 0;
	wire logic   awready, wready, bvalid, arready, rvalid, tick;
	wire logic   read_hold, command_hold, wres, cke, dqm, fast, sync;
	wire logic   qen, qmin, csel, brc;
	wire logic [1:0]  bresp, rresp, prl;
	wire logic [31:0] rdata;
	wire dtc_kind_t   kind;
	wire dtc_width_t  width;
	wire logic [8:0]  pre;
	wire logic [2:0]  outs;
	wire logic [7:0]  qmax;
	int n_fail = 0;
	int tests_run = 0;

	always #5 aclk = ~aclk;

	dtc_mem_model #(.DIV(2)) i_mem (.aclk(aclk), .aresetn(aresetn),
		.mclk_tick(tick));

	dtc_top i_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .cfg_state(cfg),
		.low_power_state(lp), .mclk_tick(tick), .write_issued(ev[0]),
		.read_wanted(rw), .powerdown_exit(ev[1]),
		.selfrefresh_exit(ev[2]), .selfrefresh_entry(ev[3]),
		.read_hold(read_hold), .command_hold(command_hold),
		.pad_read_latency(prl), .memory_kind(kind), .memory_width(width),
		.width_reserved(wres), .cke_out(cke), .dqm_out(dqm),
		.bus_faster_synchronous(fast), .clocks_synchronous(sync),
		.refresh_prescale(pre), .refresh_max_outstanding(outs),
		.master_id(mid), .qos_enable(qen), .qos_min(qmin), .qos_max(qmax),
		.bus_addr(baddr), .chip_zero_select(csel),
		.bank_row_column(brc));

	// Compare a value with its expectation
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic print_verdict;
		$display("checks=%0d mismatches=%0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Bus write; address and data offered together, each dropped when taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] er);
		int n;
		bit done;
		n = 0;
		done = 0;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		// Local flag; bready itself only settles after this time step
		while (!done && n < 50) begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
			if (bvalid) begin
				chk(bresp, er);
				bready <= 0;
				done = 1;
			end
		end
		if (!done) chk(0, 1);
		@(posedge aclk);
	endtask

	// Bus read with expected data and response
	task automatic rd(input logic [11:0] a, input logic [31:0] e,
		input logic [1:0] er);
		int n;
		bit done;
		n = 0;
		done = 0;
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		// Local flag; rready itself only settles after this time step
		while (!done && n < 50) begin
			@(posedge aclk);
			n++;
			if (arvalid && arready) arvalid <= 0;
			if (rvalid) begin
				chk(rdata, e);
				chk(rresp, er);
				rready <= 0;
				done = 1;
			end
		end
		if (!done) chk(0, 1);
		@(posedge aclk);
	endtask

	// Pulse one command event and time the hold it causes
	task automatic gap(input int i, input int k);
		int c;
		c = 0;
		ev[i] <= 1;
		@(posedge aclk);
		ev[i] <= 0;
		#1;
		while ((i == 0 ? read_hold : command_hold) && c < 600) begin
			@(posedge aclk);
			#1;
			c++;
		end
		chk(c >= 2 * k - 2 && c <= 2 * k + 2, 1);
		@(posedge aclk);
	endtask

	task automatic t_regs;
		logic [11:0] a [8] = '{12'h03c, 12'h040, 12'h044, 12'h048,
			12'h04c, 12'h050, 12'h100, 12'h200};
		logic [31:0] e [8] = '{2, 1, 32'h0a, 32'h14, 0, 0, 0, 32'hff00};
		for (int i = 0; i < 8; i++)
			rd(a[i], e[i], 2'b00);
	endtask

	task automatic t_cke;
		chk(cke, 0);
		chk(dqm, 0);
		wr(12'h04c, 32'h0000000c, 4'hf, 2'b00);
		chk(cke, 1);
		chk(dqm, 1);
		cfg <= 0;
		repeat (3) @(posedge aclk);
		chk({cke, dqm}, 2'b10);
	endtask

	// Guarded places refuse outside config and low-power states
	task automatic t_guard;
		wr(12'h03c, 32'h5, 4'hf, 2'b10);
		rd(12'h03c, 0, 2'b10);
		rd(12'h040, 1, 2'b00);
		wr(12'h0f0, 1, 4'hf, 2'b10);
		rd(12'h0f0, 0, 2'b10);
		lp <= 1;
		wr(12'h044, 32'h33, 4'hf, 2'b00);
		rd(12'h044, 32'h33, 2'b00);
		lp <= 0;
		cfg <= 1;
		rd(12'h03c, 2, 2'b00);
	endtask

	task automatic t_mem2;
		logic [31:0] v;
		for (int k = 0; k < 4; k++) begin
			v = k << 9 | k << 6 | k << 4 | 3;
			wr(12'h04c, 32'hfffff800 | v, 4'hf, 2'b00);
			rd(12'h04c, v, 2'b00);
			chk(prl, k);
			chk(kind, k);
			chk({wres, width}, {k == 3, 2'(k)});
			chk({fast, sync}, 2'b11);
		end
		wr(12'h050, 32'hfffffa5d, 4'hf, 2'b00);
		rd(12'h050, 32'ha5d, 2'b00);
		chk({pre, outs}, {9'h14b, 3'h5});
	endtask

	task automatic t_gaps;
		wr(12'h03c, 3, 4'h1, 2'b00);
		wr(12'h03c, 7, 4'h0, 2'b00);
		rd(12'h03c, 3, 2'b00);
		wr(12'h040, 5, 4'hf, 2'b00);
		wr(12'h044, 4, 4'hf, 2'b00);
		wr(12'h048, 6, 4'hf, 2'b00);
		rw <= 1;
		gap(0, 3);
		gap(1, 5);
		gap(2, 4);
		gap(3, 6);
		wr(12'h03c, 0, 4'hf, 2'b00);
		gap(0, 0);
		rw <= 0;
	endtask

	task automatic t_qos;
		wr(12'h11c, 32'h169, 4'hf, 2'b00);
		mid <= 8'he0;
		@(posedge aclk);
		chk({qen, qmin, qmax}, 10'h25a);
		mid <= 8'h20;
		@(posedge aclk);
		chk({qen, qmin, qmax}, 10'h000);
	endtask

	task automatic t_chip;
		wr(12'h200, 32'h000112f0, 4'hf, 2'b00);
		baddr <= 32'h1a000000;
		@(posedge aclk);
		chk({csel, brc}, 2'b11);
		baddr <= 32'h22000000;
		@(posedge aclk);
		chk({csel, brc}, 2'b01);
		wr(12'h200, 0, 4'hf, 2'b00);
		@(posedge aclk);
		chk({csel, brc}, 2'b10);
	endtask

	// Main sequence
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		t_regs;
		t_cke;
		t_guard;
		t_mem2;
		t_gaps;
		t_qos;
		t_chip;
		print_verdict;
	end

	// Watchdog; the tests need a few hundred cycles at most
	initial begin
		#100000;
		n_fail++;
		print_verdict;
	end
endmodule
`default_nettype wire
